// ### core/eew_defs.vh
// constants for the byte-wide eeprom host write controller
`ifndef EEW_DEFS_VH
`define EEW_DEFS_VH

`define EEW_CLK_NS     4
// address/data setup before the write strobe falls
`define EEW_T_SU_NS    20
// write strobe low time, well above the 20 ns noise filter of the part
`define EEW_T_WP_NS    100
`define EEW_T_WPH_NS   50
`define EEW_T_ACC_NS   150
`define EEW_T_OEH_NS   50
// byte load window; a whole byte cycle here is far shorter
`define EEW_T_BLC_NS   100000
`define EEW_T_WC_NS    5000000
`define EEW_SYNC_CYC   2

`define EEW_SU_CYC     ((`EEW_T_SU_NS + `EEW_CLK_NS - 1) / `EEW_CLK_NS)
`define EEW_WP_CYC     ((`EEW_T_WP_NS + `EEW_CLK_NS - 1) / `EEW_CLK_NS)
`define EEW_WPH_CYC    ((`EEW_T_WPH_NS + `EEW_CLK_NS - 1) / `EEW_CLK_NS)
`define EEW_ACC_CYC    ((`EEW_T_ACC_NS + `EEW_CLK_NS - 1) / `EEW_CLK_NS + `EEW_SYNC_CYC)
`define EEW_OEH_CYC    ((`EEW_T_OEH_NS + `EEW_CLK_NS - 1) / `EEW_CLK_NS)
`define EEW_BLC_CYC    (`EEW_T_BLC_NS / `EEW_CLK_NS)
`define EEW_WC_CYC     (`EEW_T_WC_NS / `EEW_CLK_NS)

// commands
`define EEW_OP_READ    2'h0
`define EEW_OP_WRITE   2'h1
`define EEW_OP_SDPWR   2'h2
`define EEW_OP_SDPCLR  2'h3

// protection command table (addresses and data)
`define EEW_SEQ_A0     15'h5555
`define EEW_SEQ_A1     15'h2aaa
`define EEW_SEQ_D0     8'haa
`define EEW_SEQ_D1     8'h55
`define EEW_SEQ_DWR    8'ha0
`define EEW_SEQ_DCLR   8'h80
`define EEW_SEQ_DCLR2  8'h20
`define EEW_SEQ_NWR    3'h3
`define EEW_SEQ_NCLR   3'h6

`define EEW_PAGE_BYTES 7'h40

`endif

// ### core/eew_page_buf.v
// 64-byte page buffer with registered read data
`default_nettype none
module eew_page_buf (
  input  wire       clk,
  input  wire       we,
  input  wire [5:0] waddr,
  input  wire [7:0] wdata,
  input  wire [5:0] raddr,
  output reg  [7:0] rdata_q
);
  reg [7:0] mem [0:63];

  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_q <= mem[raddr];
  end
endmodule
`default_nettype wire

// ### core/eew_host.v
// host controller driving a byte-wide eeprom: reads, page writes, protection sequences
`default_nettype none
`include "eew_defs.vh"
module eew_host #(
  parameter integer WC_CYC  = `EEW_WC_CYC,
  parameter integer TMO_CYC = 2 * `EEW_WC_CYC
) (
  input  wire        clk,
  input  wire        rst,
  input  wire        cmd_valid,
  output wire        cmd_ready,
  input  wire [1:0]  cmd_op,
  input  wire [14:0] cmd_addr,
  input  wire [6:0]  cmd_len,
  input  wire        buf_we,
  input  wire [5:0]  buf_idx,
  input  wire [7:0]  buf_wdata,
  output reg  [7:0]  rd_data_q,
  output reg         done_q,
  output reg         err_q,
  output reg  [14:0] cell_address_q,
  output reg         ce_n_q,
  output reg         oe_n_q,
  output reg         we_n_q,
  output reg  [7:0]  data_lines_o_q,
  output reg         data_lines_oe_n_q,
  input  wire [7:0]  data_lines_i
);
  localparam [7:0] S_IDLE = 8'h01;
  localparam [7:0] S_WSET = 8'h02;
  localparam [7:0] S_WLOW = 8'h04;
  localparam [7:0] S_WHI  = 8'h08;
  localparam [7:0] S_RLOW = 8'h10;
  localparam [7:0] S_RGAP = 8'h20;
  localparam [7:0] S_WAIT = 8'h40;

  // header counts are 32-bit; cut to counter width on purpose
  localparam integer SU_I    = `EEW_SU_CYC;
  localparam integer WP_I    = `EEW_WP_CYC;
  localparam integer WPH_I   = `EEW_WPH_CYC;
  localparam integer ACC_I   = `EEW_ACC_CYC;
  localparam integer OEH_I   = `EEW_OEH_CYC;
  localparam [5:0]   SU_CYC  = SU_I[5:0];
  localparam [5:0]   WP_CYC  = WP_I[5:0];
  localparam [5:0]   WPH_CYC = WPH_I[5:0];
  localparam [5:0]   ACC_CYC = ACC_I[5:0];
  localparam [5:0]   OEH_CYC = OEH_I[5:0];
  localparam [22:0]  WC_LIM  = WC_CYC[22:0];
  localparam [22:0]  TMO_LIM = TMO_CYC[22:0];

  reg [7:0]  state_q;
  reg [5:0]  cnt_q;
  reg [22:0] tmo_q;
  reg [1:0]  op_q;
  reg [14:0] base_q;
  reg [6:0]  len_q;
  reg [6:0]  idx_q;
  reg [2:0]  pstep_q;
  reg [2:0]  pnum_q;
  reg        poll_q;
  reg        havep_q;
  reg        prev6_q;
  reg [7:0]  last_q;
  reg [7:0]  sync1_q;
  reg [7:0]  sync2_q;
  wire [7:0] buf_rd;

  wire        in_pre   = (pstep_q != pnum_q);
  wire [14:0] byte_adr = {base_q[14:6], base_q[5:0] + idx_q[5:0]};
  wire        last_b   = (idx_q == len_q - 7'h01);

  assign cmd_ready = state_q[0];

  eew_page_buf u_buf (
    .clk     (clk),
    .we      (buf_we),
    .waddr   (buf_idx),
    .wdata   (buf_wdata),
    .raddr   (idx_q[5:0]),
    .rdata_q (buf_rd)
  );

  // fixed command table; a wrong entry makes the part drop the sequence
  function [22:0] seq_ent;
    input [2:0] step;
    input       clr;
    begin
      case (step)
        3'h0:    seq_ent = {`EEW_SEQ_A0, `EEW_SEQ_D0};
        3'h1:    seq_ent = {`EEW_SEQ_A1, `EEW_SEQ_D1};
        3'h2:    seq_ent = {`EEW_SEQ_A0, clr ? `EEW_SEQ_DCLR : `EEW_SEQ_DWR};
        3'h3:    seq_ent = {`EEW_SEQ_A0, `EEW_SEQ_D0};
        3'h4:    seq_ent = {`EEW_SEQ_A1, `EEW_SEQ_D1};
        default: seq_ent = {`EEW_SEQ_A0, `EEW_SEQ_DCLR2};
      endcase
    end
  endfunction

  wire [22:0] seq_w = seq_ent(pstep_q, op_q == `EEW_OP_SDPCLR);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
    end else begin
      sync1_q <= data_lines_i;
      sync2_q <= sync1_q;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q           <= S_IDLE;
      cnt_q             <= 6'h00;
      tmo_q             <= 23'h000000;
      op_q              <= `EEW_OP_READ;
      base_q            <= 15'h0000;
      len_q             <= 7'h01;
      idx_q             <= 7'h00;
      pstep_q           <= 3'h0;
      pnum_q            <= 3'h0;
      poll_q            <= 1'b0;
      havep_q           <= 1'b0;
      prev6_q           <= 1'b0;
      last_q            <= 8'h00;
      rd_data_q         <= 8'h00;
      done_q            <= 1'b0;
      err_q             <= 1'b0;
      cell_address_q    <= 15'h0000;
      ce_n_q            <= 1'b1;
      oe_n_q            <= 1'b1;
      we_n_q            <= 1'b1;
      data_lines_o_q    <= 8'h00;
      data_lines_oe_n_q <= 1'b1;
    end else begin
      done_q <= 1'b0;
      cnt_q  <= cnt_q + 6'h01;
      case (state_q)
        S_IDLE: begin
          cnt_q <= 6'h00;
          if (cmd_valid) begin
            op_q    <= cmd_op;
            base_q  <= cmd_addr;
            len_q   <= (cmd_len == 7'h00) ? 7'h01 :
                       (cmd_len > `EEW_PAGE_BYTES) ? `EEW_PAGE_BYTES : cmd_len;
            idx_q   <= 7'h00;
            pstep_q <= 3'h0;
            pnum_q  <= (cmd_op == `EEW_OP_SDPWR) ? `EEW_SEQ_NWR :
                       (cmd_op == `EEW_OP_SDPCLR) ? `EEW_SEQ_NCLR : 3'h0;
            err_q   <= 1'b0;
            havep_q <= 1'b0;
            poll_q  <= 1'b0;
            if (cmd_op == `EEW_OP_READ) begin
              cell_address_q <= cmd_addr;
              state_q        <= S_RLOW;
            end else begin
              state_q <= S_WSET;
            end
          end
        end
        // gate held high while select goes low and the bus is driven; strobe falls after the setup
        S_WSET: begin
          oe_n_q            <= 1'b1;
          ce_n_q            <= 1'b0;
          data_lines_oe_n_q <= 1'b0;
          cell_address_q    <= in_pre ? seq_w[22:8] : byte_adr;
          data_lines_o_q    <= in_pre ? seq_w[7:0] : buf_rd;
          if (!in_pre) begin
            last_q <= buf_rd;
          end
          if (cnt_q == SU_CYC) begin
            cnt_q   <= 6'h00;
            state_q <= S_WLOW;
          end
        end
        S_WLOW: begin
          we_n_q <= 1'b0;
          if (cnt_q == WP_CYC - 6'h01) begin
            cnt_q   <= 6'h00;
            state_q <= S_WHI;
          end
        end
        // strobe and select rise together; data held through the recovery
        S_WHI: begin
          we_n_q <= 1'b1;
          ce_n_q <= 1'b1;
          if (cnt_q == WPH_CYC - 6'h01) begin
            cnt_q             <= 6'h00;
            data_lines_oe_n_q <= 1'b1;
            if (in_pre) begin
              pstep_q <= pstep_q + 3'h1;
              if (pstep_q + 3'h1 == pnum_q && op_q == `EEW_OP_SDPCLR) begin
                tmo_q   <= 23'h000000;
                state_q <= S_WAIT;
              end else begin
                state_q <= S_WSET;
              end
            end else if (!last_b) begin
              idx_q   <= idx_q + 7'h01;
              state_q <= S_WSET;
            end else begin
              // idle strobe lets the part start programming; poll the last byte
              cell_address_q <= byte_adr;
              poll_q         <= 1'b1;
              tmo_q          <= 23'h000000;
              state_q        <= S_RGAP;
            end
          end
        end
        // data bus released a full gap before the part may drive it
        S_RLOW: begin
          data_lines_oe_n_q <= 1'b1;
          ce_n_q            <= 1'b0;
          oe_n_q            <= 1'b0;
          if (poll_q) begin
            tmo_q <= tmo_q + 23'h000001;
          end
          if (cnt_q == ACC_CYC - 6'h01) begin
            cnt_q     <= 6'h00;
            rd_data_q <= sync2_q;
            oe_n_q    <= 1'b1;
            ce_n_q    <= 1'b1;
            if (!poll_q) begin
              done_q  <= 1'b1;
              state_q <= S_IDLE;
            end else if (havep_q && sync2_q[6] == prev6_q &&
                         sync2_q[7] == last_q[7]) begin
              done_q  <= 1'b1;
              state_q <= S_IDLE;
            end else if (tmo_q >= TMO_LIM) begin
              err_q   <= 1'b1;
              done_q  <= 1'b1;
              state_q <= S_IDLE;
            end else begin
              prev6_q <= sync2_q[6];
              havep_q <= 1'b1;
              state_q <= S_RGAP;
            end
          end
        end
        S_RGAP: begin
          oe_n_q            <= 1'b1;
          ce_n_q            <= 1'b1;
          data_lines_oe_n_q <= 1'b1;
          tmo_q             <= tmo_q + 23'h000001;
          if (cnt_q == OEH_CYC - 6'h01) begin
            cnt_q   <= 6'h00;
            state_q <= S_RLOW;
          end
        end
        // clearing gives no polling status, so wait out the cycle time
        S_WAIT: begin
          cnt_q <= 6'h00;
          tmo_q <= tmo_q + 23'h000001;
          if (tmo_q >= WC_LIM - 23'h000001) begin
            done_q  <= 1'b1;
            state_q <= S_IDLE;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ### verif/eew_host_monitor.sv
// pin protocol checker for the eeprom host controller
`default_nettype none
module eew_host_monitor (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        cmd_valid,
  input wire logic        cmd_ready,
  input wire logic [1:0]  cmd_op,
  input wire logic        done_q,
  input wire logic [14:0] cell_address_q,
  input wire logic        ce_n_q,
  input wire logic        oe_n_q,
  input wire logic        we_n_q,
  input wire logic [7:0]  data_lines_o_q,
  input wire logic        data_lines_oe_n_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_rst_idle; $fell(rst) |-> ce_n_q && oe_n_q && we_n_q && data_lines_oe_n_q && cmd_ready; endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("pins not idle after reset");
  property p_no_fight; !oe_n_q |-> data_lines_oe_n_q; endproperty
  a_no_fight: assert property (p_no_fight) else $error("host drives data during read");
  property p_rd_sel; !oe_n_q |-> !ce_n_q && we_n_q; endproperty
  a_rd_sel: assert property (p_rd_sel) else $error("read gate without select");
  property p_wr_mix; !we_n_q |-> !ce_n_q && oe_n_q && !data_lines_oe_n_q; endproperty
  a_wr_mix: assert property (p_wr_mix) else $error("bad write strobe mix");
  property p_adr_hold; !we_n_q && !$fell(we_n_q) |-> $stable(cell_address_q); endproperty
  a_adr_hold: assert property (p_adr_hold) else $error("address moved in write pulse");
  property p_dat_rise; $rose(we_n_q) |-> $stable(data_lines_o_q) && !data_lines_oe_n_q; endproperty
  a_dat_rise: assert property (p_dat_rise) else $error("data not held at strobe rise");
  property p_wide; $fell(we_n_q) |-> !we_n_q [*8]; endproperty
  a_wide: assert property (p_wide) else $error("write pulse too short");
  property p_rd_done; cmd_valid && cmd_ready && cmd_op == 2'h0 |-> ##41 done_q; endproperty
  a_rd_done: assert property (p_rd_done) else $error("read answer late");
endmodule
bind eew_host eew_host_monitor u_mon (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
  .cmd_op(cmd_op), .done_q(done_q), .cell_address_q(cell_address_q), .ce_n_q(ce_n_q), .oe_n_q(oe_n_q),
  .we_n_q(we_n_q), .data_lines_o_q(data_lines_o_q), .data_lines_oe_n_q(data_lines_oe_n_q));
`default_nettype wire

// ### verif/eew_mem_model.sv
// behavioural byte-wide eeprom: page load, status polling, protection
`default_nettype none
`include "eew_defs.vh"
module eew_mem_model #(parameter int BLC = 100, parameter int PRG = 300) (
  input  wire logic        clk,
  input  wire logic [14:0] addr,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [7:0]  din,
  output logic      [7:0]  dout
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [45:0]  KEY = {`EEW_SEQ_A0, `EEW_SEQ_D0, `EEW_SEQ_A1, `EEW_SEQ_D1};
  localparam logic [68:0]  UNL = {KEY, `EEW_SEQ_A0, `EEW_SEQ_DWR};
  localparam logic [137:0] CLR = {KEY, `EEW_SEQ_A0, `EEW_SEQ_DCLR, KEY, `EEW_SEQ_A0, `EEW_SEQ_DCLR2};
  logic [7:0]   mem [0:32767];
  logic [22:0]  ld[$];
  logic [22:0]  last = '0;
  logic [137:0] cat;
  logic [14:0]  a_q = '0;
  logic [7:0]   rd_q = '0;
  logic         sdp_q = 1'b0;
  logic         tog = 1'b0;
  logic         we_d = 1'b1;
  logic         ce_d = 1'b1;
  logic         oe_d = 1'b1;
  int           idle = 0;
  int           busy = 0;
  int           n;
  // released bus shows the inverse, so a stale value never looks valid
  assign dout = (!ce_n && !oe_n) ? rd_q : ~rd_q;
  initial begin
    for (int i = 0; i < 32768; i++) mem[i] = 8'hff;
  end
  always @(posedge clk) begin
    if (busy > 0) busy--;
    if (!we_n && we_d && !ce_n && oe_n) begin
      a_q = addr;
      idle = 0;
    end
    if (we_n && !we_d && !ce_d && oe_d && busy == 0) ld.push_back({a_q, din});
    if (!oe_n && oe_d && !ce_n) begin
      rd_q <= busy > 0 ? {~last[7], tog, last[5:0]} : mem[addr];
      tog = ~tog;
    end
    idle++;
    if (ld.size() > 0 && idle > BLC) begin
      cat = '0;
      for (int i = 0; i < 6 && i < ld.size(); i++) cat[137-23*i -: 23] = ld[i];
      n = 0;
      if (ld.size() == 6 && cat == CLR) begin
        sdp_q <= 1'b0;
        busy = PRG;
        n = 6;
      end else if (ld.size() > 3 && cat[137:69] == UNL) begin
        sdp_q <= 1'b1;
        n = 3;
      end else if (sdp_q) n = ld.size();
      for (int i = n; i < ld.size(); i++) mem[ld[i][22:8]] = ld[i][7:0];
      if (n < ld.size()) begin
        last = ld[$];
        busy = PRG;
      end
      ld.delete();
    end
    we_d = we_n;
    ce_d = ce_n;
    oe_d = oe_n;
  end
endmodule
`default_nettype wire

// ### verif/eew_host_tb_top.sv
// self-checking bench for the eeprom host controller
`default_nettype none
`include "eew_defs.vh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module eew_host_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, cmd_valid, buf_we;
  logic [1:0]  cmd_op;
  logic [14:0] cmd_addr;
  logic [6:0]  cmd_len;
  logic [5:0]  buf_idx;
  logic [7:0]  buf_wdata;
  wire         cmd_ready, done_q, err_q, ce_n_q, oe_n_q, we_n_q, data_lines_oe_n_q;
  wire  [7:0]  rd_data_q, data_lines_o_q, dev, bus;
  wire  [14:0] cell_address_q;
  int          error_cnt = 0;
  int          check_count = 0;
  assign bus = data_lines_oe_n_q ? dev : data_lines_o_q;
  eew_host #(.WC_CYC(500), .TMO_CYC(2000)) uut (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_len(cmd_len), .buf_we(buf_we),
    .buf_idx(buf_idx), .buf_wdata(buf_wdata), .rd_data_q(rd_data_q), .done_q(done_q), .err_q(err_q),
    .cell_address_q(cell_address_q), .ce_n_q(ce_n_q), .oe_n_q(oe_n_q), .we_n_q(we_n_q),
    .data_lines_o_q(data_lines_o_q), .data_lines_oe_n_q(data_lines_oe_n_q), .data_lines_i(bus));
  eew_mem_model mdl (.clk(clk), .addr(cell_address_q), .ce_n(ce_n_q), .oe_n(oe_n_q), .we_n(we_n_q),
    .din(data_lines_o_q), .dout(dev));
  task automatic finish_test();
    if (error_cnt == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic load(input logic [5:0] i, input logic [7:0] d);
    @(negedge clk);
    buf_idx = i;
    buf_wdata = d;
    buf_we = 1'b1;
    @(negedge clk);
    buf_we = 1'b0;
  endtask
  task automatic run(input logic [1:0] op, input logic [14:0] a, input logic [6:0] n);
    int t;
    @(negedge clk);
    cmd_op = op;
    cmd_addr = a;
    cmd_len = n;
    cmd_valid = 1'b1;
    // idle controller takes it at the next rising edge
    @(negedge clk);
    cmd_valid = 1'b0;
    t = 0;
    while (done_q !== 1'b1 && t < 5000) begin
      @(negedge clk);
      t++;
    end
    `CHK("done", 1'b1, done_q)
  endtask
  task automatic rd(input logic [14:0] a, input logic [7:0] e);
    run(`EEW_OP_READ, a, 7'h01);
    `CHK("rdata", e, rd_data_q)
  endtask
  task automatic t_idle();
    `CHK("ce_n", 1'b1, ce_n_q)
    `CHK("doe_n", 1'b1, data_lines_oe_n_q)
    `CHK("sdp", 1'b0, mdl.sdp_q)
  endtask
  task automatic t_page();
    load(6'h00, 8'h3c);
    load(6'h01, 8'hc5);
    run(`EEW_OP_WRITE, 15'h0abf, 7'h02);
    `CHK("err", 1'b0, err_q)
    rd(15'h0abf, 8'h3c);
    rd(15'h0a80, 8'hc5);
  endtask
  task automatic t_lock();
    load(6'h00, 8'h5a);
    run(`EEW_OP_SDPWR, 15'h0100, 7'h01);
    `CHK("sdp", 1'b1, mdl.sdp_q)
    rd(15'h0100, 8'h5a);
    load(6'h00, 8'h91);
    run(`EEW_OP_WRITE, 15'h0100, 7'h01);
    `CHK("err", 1'b1, err_q)
    rd(15'h0100, 8'h5a);
  endtask
  task automatic t_clear();
    run(`EEW_OP_SDPCLR, 15'h0000, 7'h01);
    `CHK("sdp", 1'b0, mdl.sdp_q)
    load(6'h00, 8'h77);
    run(`EEW_OP_WRITE, 15'h0100, 7'h01);
    rd(15'h0100, 8'h77);
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #160000;
    error_cnt++;
    finish_test();
  end
  initial begin
    rst = 1'b1;
    cmd_valid = 1'b0;
    buf_we = 1'b0;
    cmd_op = 2'h0;
    cmd_addr = 15'h0000;
    cmd_len = 7'h00;
    buf_idx = 6'h00;
    buf_wdata = 8'h00;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_idle();
    t_page();
    t_lock();
    t_clear();
    finish_test();
  end
endmodule
`default_nettype wire
